// [spd_pkg.sv]
// Package of constants and types for the segment panel drive timing block
// How it works
// - The source clock is divided by a 16-bit prescaler by two to the power of a 4-bit exponent, ratio 1 to 32768.
// - The prescaled clock is divided again by sixteen plus a 4-bit fine offset, a factor of 16 to 31, giving the panel clock.
// - Each panel clock outside dead time steps one backplane phase, so a frame lasts as many phases as the duty setting has commons.
// - A blink prescaler counts frames and its rate is picked by a 3-bit select from 0 to 7.
// - With external supply selected, up to seven dead phases follow each frame pair with backplane and segments low.
// - With internal supply selected, an eight-step contrast level is passed to the booster.
// - Setting the drive enable closes the ladder connect switch at once.
// - Clearing the drive enable keeps the switch closed until the even frame in progress ends, or in an odd frame or dead time, the next even frame.
// - With force and pulse length both zero the strong-drive signal stays open.
// - With force zero and nonzero pulse length, strong drive closes for that many pulses at each level change.
// - With force set the strong-drive signal is always closed.
// - A pixel memory holds one bit per pixel, one to light it.
// - The controller runs in every low power mode except halt, where it stops.
// - Odd and even frames alternate; the selected backplane is lowest in odd frames and highest in even frames.
package spd_pkg;
  localparam int SPD_PRESCALE_W = 16;
  localparam int SPD_FINE_BASE = 16;
  localparam int SPD_NUM_COMMONS = 8;
  localparam int SPD_NUM_SEGMENTS = 40;
  localparam int SPD_ADDR_W = 3;
  localparam logic [15:0] SPD_PRESCALE_RST = 16'h0000;
  localparam logic [4:0] SPD_FINE_RST = 5'h00;
  localparam logic [3:0] SPD_BLINK_RST = 4'h0;
  localparam logic [2:0] SPD_PULSE_RST = 3'h0;
  localparam logic [2:0] SPD_DEAD_RST = 3'h0;
  localparam logic [2:0] SPD_PHASE_RST = 3'h0;

  typedef enum logic [2:0] {
    SPD_DUTY_STATIC = 3'h0,
    SPD_DUTY_HALF = 3'h1,
    SPD_DUTY_THIRD = 3'h2,
    SPD_DUTY_QUARTER = 3'h3,
    SPD_DUTY_EIGHTH = 3'h4
  } spd_duty_t;

  typedef enum logic [1:0] {
    SPD_ST_OFF = 2'b00,
    SPD_ST_DRIVE = 2'b01,
    SPD_ST_DEAD = 2'b11,
    SPD_ST_DRAIN = 2'b10
  } spd_state_t;
endpackage

// [spd_mem_if.sv]
// Interface between the controller and its pixel memory
`timescale 1ns/1ps
interface spd_mem_if #(parameter int AW = 3, parameter int DW = 40);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [spd_pixel_mem.sv]
// Pixel memory, one row per backplane line, registered read
`timescale 1ns/1ps
module spd_pixel_mem import spd_pkg::*; #(
  parameter int ROWS = SPD_NUM_COMMONS,
  parameter int AW = SPD_ADDR_W,
  parameter int DW = SPD_NUM_SEGMENTS
) (
  // Clock
  input wire logic ref_clk,
  // Access
  spd_mem_if.mem port
);
  logic [DW-1:0] pixel_memory [ROWS];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      pixel_memory[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    rdata_r <= pixel_memory[port.raddr];
  end

  assign port.rdata = rdata_r;
endmodule // spd_pixel_mem

// [spd_panel_timing.sv]
// Top of the segment panel drive timing block
`timescale 1ns/1ps
module spd_panel_timing import spd_pkg::*; #(
  parameter int COMMONS = SPD_NUM_COMMONS,
  parameter int SEGMENTS = SPD_NUM_SEGMENTS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Configuration
  input wire logic panel_drive_enable,
  input wire logic [3:0] prescale_exponent,
  input wire logic [3:0] fine_offset,
  input wire logic [2:0] duty_select,
  input wire logic [2:0] blink_rate_select,
  input wire logic supply_external,
  input wire logic [2:0] dead_time_phases,
  input wire logic [2:0] contrast_step,
  input wire logic [2:0] pulse_on_length,
  input wire logic strong_drive_force,
  input wire logic halt_mode,
  // Pixel memory write
  input wire logic pixel_we,
  input wire logic [SPD_ADDR_W-1:0] pixel_row,
  input wire logic [SEGMENTS-1:0] pixel_data,
  // Panel side
  output logic ladder_switch_closed,
  output logic strong_drive_closed,
  output logic [2:0] booster_level,
  output logic [SPD_ADDR_W-1:0] backplane_line,
  output logic even_frame,
  output logic dead_phase,
  output logic [SEGMENTS-1:0] segment_data,
  output logic blink_tick,
  output logic panel_clock
);
  // ----------------------------------------
  // Frequency generator
  // ----------------------------------------
  spd_state_t state_r;
  logic run;
  logic [SPD_PRESCALE_W-1:0] pre_cnt_r;
  logic [4:0] fine_cnt_r;
  logic ps_tick;
  logic phase_tick;
  logic [SPD_PRESCALE_W:0] pre_mask;
  logic [4:0] fine_max;

  // Halt stops the prescaler and every count it drives; other low power modes leave it running
  assign run = (state_r != SPD_ST_OFF) && !halt_mode;
  assign pre_mask = (17'h00001 << prescale_exponent) - 17'h00001;
  assign ps_tick = run && ((pre_cnt_r & pre_mask[SPD_PRESCALE_W-1:0]) == pre_mask[SPD_PRESCALE_W-1:0]);
  assign fine_max = 5'(SPD_FINE_BASE - 1) + {1'b0, fine_offset};
  assign phase_tick = ps_tick && (fine_cnt_r == fine_max);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= SPD_PRESCALE_RST;
    end else if (state_r == SPD_ST_OFF) begin
      pre_cnt_r <= SPD_PRESCALE_RST;
    end else if (run) begin
      pre_cnt_r <= pre_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fine_cnt_r <= SPD_FINE_RST;
    end else if (state_r == SPD_ST_OFF) begin
      fine_cnt_r <= SPD_FINE_RST;
    end else if (ps_tick) begin
      fine_cnt_r <= (fine_cnt_r == fine_max) ? SPD_FINE_RST : fine_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      panel_clock <= 1'b0;
    end else begin
      panel_clock <= phase_tick;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  logic [2:0] phase_r;
  logic [2:0] last_phase;
  logic [2:0] dead_cnt_r;
  logic frame_end;

  always_comb begin
    unique case (duty_select)
      SPD_DUTY_HALF: last_phase = 3'h1;
      SPD_DUTY_THIRD: last_phase = 3'h2;
      SPD_DUTY_QUARTER: last_phase = 3'h3;
      SPD_DUTY_EIGHTH: last_phase = 3'h7;
      default: last_phase = 3'h0;
    endcase
  end

  assign frame_end = phase_tick && (state_r != SPD_ST_DEAD) && (phase_r == last_phase);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SPD_ST_OFF;
    end else begin
      unique case (state_r)
        SPD_ST_OFF: if (panel_drive_enable) state_r <= SPD_ST_DRIVE;
        SPD_ST_DRIVE: begin
          // Cleared on the last tick of an even frame: open now, not a pair later
          if (!panel_drive_enable && frame_end && even_frame) begin
            state_r <= SPD_ST_OFF;
          end else if (!panel_drive_enable) begin
            state_r <= SPD_ST_DRAIN;
          end else if (frame_end && even_frame && supply_external && dead_time_phases != 3'h0) begin
            state_r <= SPD_ST_DEAD;
          end
        end
        SPD_ST_DEAD: begin
          // Dead time cut short; the switch still opens only after an even frame
          if (!panel_drive_enable) begin
            state_r <= SPD_ST_DRAIN;
          end else if (phase_tick && dead_cnt_r == dead_time_phases) begin
            state_r <= SPD_ST_DRIVE;
          end
        end
        SPD_ST_DRAIN: begin
          if (panel_drive_enable) begin
            state_r <= SPD_ST_DRIVE;
          end else if (frame_end && even_frame) begin
            state_r <= SPD_ST_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= SPD_PHASE_RST;
      even_frame <= 1'b0;
    end else if (state_r == SPD_ST_OFF) begin
      phase_r <= SPD_PHASE_RST;
      even_frame <= 1'b0;
    end else if (frame_end) begin
      phase_r <= SPD_PHASE_RST;
      even_frame <= !even_frame;
    end else if (phase_tick && state_r != SPD_ST_DEAD) begin
      phase_r <= phase_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dead_cnt_r <= SPD_DEAD_RST;
    end else if (state_r != SPD_ST_DEAD) begin
      dead_cnt_r <= 3'h1;
    end else if (phase_tick) begin
      dead_cnt_r <= dead_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ladder_switch_closed <= 1'b0;
      dead_phase <= 1'b0;
      backplane_line <= SPD_PHASE_RST;
      booster_level <= 3'h0;
    end else begin
      ladder_switch_closed <= panel_drive_enable || (state_r != SPD_ST_OFF && !(frame_end && even_frame));
      dead_phase <= state_r == SPD_ST_DEAD;
      backplane_line <= phase_r;
      booster_level <= supply_external ? 3'h0 : contrast_step;
    end
  end

  // ----------------------------------------
  // Pixel memory and segment data
  // ----------------------------------------
  spd_mem_if #(.AW(SPD_ADDR_W), .DW(SEGMENTS)) mem_bus ();

  assign mem_bus.we = pixel_we;
  assign mem_bus.waddr = pixel_row;
  assign mem_bus.wdata = pixel_data;
  assign mem_bus.raddr = phase_r;

  spd_pixel_mem #(.ROWS(COMMONS), .AW(SPD_ADDR_W), .DW(SEGMENTS)) u_mem (
    .ref_clk(ref_clk),
    .port(mem_bus.mem)
  );

  // Dead phases drive all segments low alongside the backplane
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      segment_data <= '0;
    end else begin
      segment_data <= (state_r == SPD_ST_DEAD || state_r == SPD_ST_OFF) ? '0 : mem_bus.rdata;
    end
  end

  // ----------------------------------------
  // Blink prescaler and strong drive
  // ----------------------------------------
  logic [7:0] blink_cnt_r;
  logic [7:0] blink_mask;
  logic [2:0] pulse_cnt_r;

  assign blink_mask = (8'h02 << blink_rate_select) - 8'h01;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt_r <= 8'h00;
      blink_tick <= 1'b0;
    end else if (state_r == SPD_ST_OFF) begin
      blink_cnt_r <= 8'h00;
      blink_tick <= 1'b0;
    end else begin
      blink_tick <= frame_end && ((blink_cnt_r & blink_mask) == blink_mask);
      if (frame_end) blink_cnt_r <= blink_cnt_r + 8'h01;
    end
  end

  // Each phase step is a level change; pulses count prescaled ticks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt_r <= SPD_PULSE_RST;
    end else if (state_r == SPD_ST_OFF) begin
      pulse_cnt_r <= SPD_PULSE_RST;
    end else if (phase_tick) begin
      pulse_cnt_r <= pulse_on_length;
    end else if (ps_tick && pulse_cnt_r != 3'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strong_drive_closed <= 1'b0;
    end else begin
      strong_drive_closed <= strong_drive_force || (pulse_on_length != 3'h0 && pulse_cnt_r != 3'h0);
    end
  end
endmodule // spd_panel_timing

// [spd_glass_model.sv]
// Passive glass model that keeps the last row seen on each backplane line
`timescale 1ns/1ps
module spd_glass_model import spd_pkg::*; #(
  parameter int SEGMENTS = SPD_NUM_SEGMENTS
) (
  // Clock
  input wire logic ref_clk,
  // Panel side
  input wire logic ladder_switch_closed,
  input wire logic dead_phase,
  input wire logic [SPD_ADDR_W-1:0] backplane_line,
  input wire logic [SEGMENTS-1:0] segment_data
);
  logic [SEGMENTS-1:0] image [0:SPD_NUM_COMMONS-1];
  // Last write in a phase wins, so a one-cycle lag between line and data is harmless
  always_ff @(posedge ref_clk) begin
    if (ladder_switch_closed && !dead_phase) begin
      image[backplane_line] <= segment_data;
    end
  end
endmodule // spd_glass_model

// [spd_panel_timing_checker.sv]
// Concurrent checks on the ports of the panel drive timing block
`timescale 1ns/1ps
module spd_panel_timing_checker import spd_pkg::*; #(
  parameter int SEGMENTS = SPD_NUM_SEGMENTS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Configuration
  input wire logic panel_drive_enable,
  input wire logic [3:0] prescale_exponent,
  input wire logic supply_external,
  input wire logic [2:0] contrast_step,
  input wire logic [2:0] pulse_on_length,
  input wire logic strong_drive_force,
  input wire logic halt_mode,
  // Panel side
  input wire logic ladder_switch_closed,
  input wire logic strong_drive_closed,
  input wire logic [2:0] booster_level,
  input wire logic even_frame,
  input wire logic dead_phase,
  input wire logic [SEGMENTS-1:0] segment_data,
  input wire logic blink_tick,
  input wire logic panel_clock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Shortest legal phase is sixteen cycles
  sequence s_quiet;
    (!panel_clock) [*7];
  endsequence
  chk_clock_spacing: assert property (panel_clock |=> s_quiet ##1 s_quiet)
    else $error("panel clock pulses too close");
  chk_enable_close: assert property ($rose(panel_drive_enable) |=> ladder_switch_closed)
    else $error("switch not closed after enable");
  chk_drain_hold: assert property (!panel_drive_enable && ladder_switch_closed && !even_frame &&
    !$past(even_frame) |=> ladder_switch_closed) else $error("switch opened before even frame");
  chk_force_closed: assert property (strong_drive_force && $past(strong_drive_force) &&
    ladder_switch_closed |-> strong_drive_closed) else $error("strong drive open while forced");
  chk_no_pulse: assert property (!strong_drive_force && !$past(strong_drive_force) &&
    pulse_on_length == 3'h0 && $past(pulse_on_length) == 3'h0 |-> !strong_drive_closed)
    else $error("strong drive closed with no pulse length");
  chk_pulse_ends: assert property (strong_drive_closed && !strong_drive_force &&
    !$past(strong_drive_force) && prescale_exponent <= 4'h4 |-> ##[1:200] !strong_drive_closed)
    else $error("strong drive pulse never ends");
  chk_booster_int: assert property (!supply_external |=> booster_level == $past(contrast_step))
    else $error("booster level differs from contrast step");
  chk_booster_ext: assert property (supply_external |=> booster_level == 3'h0)
    else $error("booster level nonzero on external supply");
  chk_dead_blank: assert property (dead_phase |-> segment_data == '0 && supply_external)
    else $error("segments driven in dead phase");
  chk_halt_freeze: assert property (halt_mode && $past(halt_mode) |-> !panel_clock && !blink_tick)
    else $error("counters run in halt");
  chk_off_quiet: assert property (!panel_drive_enable && !$past(ladder_switch_closed) |->
    !panel_clock && !blink_tick) else $error("counters run while disabled");
endmodule // spd_panel_timing_checker
bind spd_panel_timing spd_panel_timing_checker #(.SEGMENTS(SEGMENTS)) u_chk (.ref_clk, .rst_b,
  .panel_drive_enable, .prescale_exponent, .supply_external, .contrast_step, .pulse_on_length,
  .strong_drive_force, .halt_mode, .ladder_switch_closed, .strong_drive_closed, .booster_level,
  .even_frame, .dead_phase, .segment_data, .blink_tick, .panel_clock);

// [tb_spd_panel_timing.sv]
// Testbench of the segment panel drive timing block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, e, s); end end
module tb_spd_panel_timing import spd_pkg::*; ;
  // ----------------------------------------
  // Stimulus and observed outputs
  // ----------------------------------------
  logic ref_clk = 1'b0, rst_b = 1'b0, en = 1'b0, ext = 1'b0, frc = 1'b0, halt = 1'b0, we = 1'b0, saw;
  logic [3:0] ps = 4'h0, fo = 4'h0;
  logic [2:0] du = 3'h1, bk = 3'h0, dt = 3'h0, ct = 3'h0, pon = 3'h0, row = 3'h0;
  logic [39:0] data = 40'h0;
  logic lad, sdc, evn, ded, blk, pclk;
  logic [2:0] bst, bpl;
  logic [39:0] seg;
  int n_checks = 0, n_mismatch = 0;
  // Period is arbitrary here; every check counts cycles, not time
  initial forever #10 ref_clk = ~ref_clk;
  spd_panel_timing u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .panel_drive_enable(en), .prescale_exponent(ps),
    .fine_offset(fo), .duty_select(du), .blink_rate_select(bk), .supply_external(ext), .dead_time_phases(dt),
    .contrast_step(ct), .pulse_on_length(pon), .strong_drive_force(frc), .halt_mode(halt), .pixel_we(we),
    .pixel_row(row), .pixel_data(data), .ladder_switch_closed(lad), .strong_drive_closed(sdc),
    .booster_level(bst), .backplane_line(bpl), .even_frame(evn), .dead_phase(ded), .segment_data(seg),
    .blink_tick(blk), .panel_clock(pclk));
  spd_glass_model u_glass (.ref_clk(ref_clk), .ladder_switch_closed(lad), .dead_phase(ded),
    .backplane_line(bpl), .segment_data(seg));
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? pclk : s == 1 ? blk : s == 2 ? evn : sdc;
  endfunction
  // Cycles between two rising edges of one output
  task automatic gap(input int s, output int n);
    int hit;
    logic p;
    hit = 0;
    n = 0;
    p = sig(s);
    for (int k = 0; k < 70000 && hit < 2; k++) begin
      cyc(1);
      if (hit == 1) n++;
      if (sig(s) === 1'b1 && p !== 1'b1) hit++;
      p = sig(s);
    end
    if (hit < 2) begin
      n_mismatch++;
      $display("Error output %0d edges expected 2 seen %0d", s, hit);
      close_out();
    end
  endtask
  task automatic cnt(input int s, input int m, output int c);
    c = 0;
    repeat (m) begin cyc(1); c += (sig(s) === 1'b1); end
  endtask
  // Disable and wait for the switch to open, noting any even frame
  task automatic off();
    int k;
    saw = 1'b0;
    en = 1'b0;
    for (k = 0; k < 3000 && lad !== 1'b0; k++) begin cyc(1); saw |= (evn === 1'b1); end
    if (lad !== 1'b0) begin
      n_mismatch++;
      $display("Error ladder switch expected 0 seen %b", lad);
      close_out();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_div();
    int n, tp[4] = '{0, 0, 2, 1}, tf[4] = '{0, 15, 3, 15};
    for (int i = 0; i < 4; i++) begin
      ps = 4'(tp[i]); fo = 4'(tf[i]); gap(0, n); gap(0, n);
      `CHK("panel clock period", (1 << tp[i]) * (16 + tf[i]), n)
    end
    ps = 4'h0; fo = 4'h0;
    $display("test divider done");
  endtask
  task automatic t_strong();
    int n;
    frc = 1'b1; cyc(3); cnt(3, 20, n);
    `CHK("forced strong drive", 20, n)
    frc = 1'b0; cyc(3); cnt(3, 40, n);
    `CHK("strong drive off", 0, n)
    for (int p = 1; p < 8; p++) begin
      // Pulses start at the phase step itself, so count from there
      pon = 3'(p); gap(0, n); gap(0, n); cnt(3, 16, n);
      `CHK("strong drive pulses", p, n)
    end
    pon = 3'h0;
    $display("test strong drive done");
  endtask
  task automatic t_blink();
    int n;
    for (int b = 0; b < 8; b++) begin
      bk = 3'(b); gap(1, n); gap(1, n);
      `CHK("blink period", (2 << b) * 32, n)
    end
    $display("test blink done");
  endtask
  task automatic t_halt();
    int n;
    halt = 1'b1; cnt(0, 100, n);
    `CHK("pulses in halt", 0, n)
    halt = 1'b0; gap(0, n); gap(0, n);
    `CHK("period after halt", 16, n)
    $display("test halt done");
  endtask
  task automatic t_supply();
    int n;
    for (int c = 0; c < 8; c++) begin ct = 3'(c); cyc(3); `CHK("booster level", 3'(c), bst) end
    ext = 1'b1;
    for (int d = 0; d < 8; d += 7) begin
      dt = 3'(d); gap(2, n); gap(2, n);
      `CHK("pair with dead time", (4 + d) * 16, n)
    end
    `CHK("booster external", 3'h0, bst)
    ext = 1'b0;
    $display("test supply done");
  endtask
  task automatic t_duty();
    int n, nc[5] = '{1, 2, 3, 4, 8};
    for (int i = 0; i < 5; i++) begin
      off(); du = 3'(i); en = 1'b1; gap(2, n); gap(2, n);
      `CHK("frame pair length", 2 * nc[i] * 16, n)
    end
    $display("test duty done");
  endtask
  task automatic t_drain();
    for (int k = 0; k < 500 && evn !== 1'b0; k++) cyc(1);
    if (evn !== 1'b0) begin
      n_mismatch++;
      $display("Error odd frame wait expected 0 seen %b", evn);
      close_out();
    end
    off();
    `CHK("even frame before open", 1'b1, saw)
    en = 1'b1; cyc(1);
    `CHK("switch closed", 1'b1, lad)
    $display("test drain done");
  endtask
  task automatic t_pixel();
    off(); du = 3'h4; we = 1'b1;
    for (int r = 0; r < 8; r++) begin row = 3'(r); data = {8{5'(r + 3)}}; cyc(1); end
    we = 1'b0; en = 1'b1; cyc(300);
    for (int r = 0; r < 8; r++) `CHK("glass row", {8{5'(r + 3)}}, u_glass.image[r])
    $display("test pixel done");
  endtask
  initial begin
    cyc(20); rst_b = 1'b1; cyc(2); en = 1'b1;
    t_div(); t_strong(); t_blink(); t_halt(); t_supply(); t_duty(); t_drain(); t_pixel();
    close_out();
  end
endmodule // tb_spd_panel_timing
